// ==== lacr_defines.svh ====
/*
 Constants for the load adaptive current regulator: widths, reset values, scaling.
 Assumes inclusion by bare name from the package, ahead of the design modules.
*/
`ifndef LACR_DEFINES_SVH
`define LACR_DEFINES_SVH

`define LACR_LOAD_W        10
`define LACR_SCALE_W       5
`define LACR_THR_SHIFT     5
`define LACR_FILT_DEPTH    4
`define LACR_CNT_W         6
`define LACR_SCALE_RST     5'h1f
`define LACR_LOAD_RST      10'h000

`endif

// ==== lacr_pkg.sv ====
/*
 Types shared by the regulator files.
 Assumes lacr_defines.svh is on the include path.
*/
`include "lacr_defines.svh"

package lacr_pkg;
   typedef logic [`LACR_LOAD_W-1:0]  lacr_load_t;
   typedef logic [`LACR_SCALE_W-1:0] lacr_scale_t;
   typedef enum logic [1:0] {
      LACR_ST_IDLE   = 2'b00,
      LACR_ST_UPDATE = 2'b01,
      LACR_ST_ADAPT  = 2'b10
   } lacr_state_t;
endpackage

// ==== lacr_load_filter.sv ====
/*
 Load result filter: averages four per-fullstep measurements when enabled,
 passes each measurement through otherwise.
 Assumes meas_valid_in is a one-cycle pulse per full step on mclk_in.
*/
`timescale 1ns/100ps

module lacr_load_filter
   import lacr_pkg::*;
(
   input  wire logic              mclk_in,        // System clock
   input  wire logic              rst_n_in,       // Async reset, active low
   input  wire logic              filt_en_in,     // Filter enable
   input  wire logic              meas_valid_in,  // One measurement per full step
   input  wire lacr_pkg::lacr_load_t meas_in,     // Raw measurement
   output logic                   res_valid_out,  // New result pulse
   output lacr_pkg::lacr_load_t   res_out         // Load result
);
   import lacr_pkg::*;

   logic [`LACR_LOAD_W+1:0] sum_r, sum_nxt;
   logic [1:0]              cnt_r, cnt_nxt;
   logic                    vld_r, vld_nxt;
   lacr_load_t              res_r, res_nxt;
   logic [`LACR_LOAD_W+1:0] sum_full;

   always_comb begin
      sum_full = sum_r + {2'b00, meas_in};
      sum_nxt  = sum_r;
      cnt_nxt  = cnt_r;
      vld_nxt  = 1'b0;
      res_nxt  = res_r;
      if (meas_valid_in) begin
         if (filt_en_in) begin
            if (cnt_r == 2'h3) begin
               res_nxt = sum_full[`LACR_LOAD_W+1:2];
               vld_nxt = 1'b1;
               sum_nxt = '0;
               cnt_nxt = 2'h0;
            end else begin
               sum_nxt = sum_full;
               cnt_nxt = cnt_r + 2'h1;
            end
         end else begin
            res_nxt = meas_in;
            vld_nxt = 1'b1;
            sum_nxt = '0;
            cnt_nxt = 2'h0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sum_r <= '0;
         cnt_r <= 2'h0;
         vld_r <= 1'b0;
         res_r <= `LACR_LOAD_RST;
      end else begin
         sum_r <= sum_nxt;
         cnt_r <= cnt_nxt;
         vld_r <= vld_nxt;
         res_r <= res_nxt;
      end
   end

   assign res_valid_out = vld_r;
   assign res_out       = res_r;
endmodule // lacr_load_filter

// ==== lacr_regulator.sv ====
/*
 Load adaptive current regulator: takes per-fullstep load measurements,
 optionally filters them, and adapts the coil current scale between a floor
 and the run current setting.
 Assumes the measurement front end and configuration bits are on mclk_in.
*/
// Notes on behaviour
// - The load result is refreshed once per full step with the filter off, and no more often.
// - With the filter enabled the result is the average of four step readings.
// - The load result is 10-bit unsigned; the lower threshold times 32 spans its lower half.
// - The lower threshold is 4-bit and zero turns the regulation off.
// - A result below lower threshold times 32 raises the coil current scale.
// - Upper threshold is (lower + hysteresis + 1) times 32; enough results at or above it lower the scale.
// - Each low result adds 1, 2, 4 or 8 to the scale as the increment field selects.
// - The scale drops by one after 32, 8, 2 or 1 high results as the decrement field selects.
// - The floor is half the run current, or a quarter when the minimum-scale bit is set.
// - The actual scale is a 5-bit status bounded by the run current and the floor.
// - With the filter on, result rate and regulation speed fall by four.
// - Regulation stays between the floor and the run current, never above it.
// - Stall sensitivity is signed, zero neutral, higher values need more torque.
`timescale 1ns/100ps

module lacr_regulator
   import lacr_pkg::*;
#(
   parameter int SENS_W = 7
)(
   input  wire logic                 mclk_in,                  // 200 MHz system clock
   input  wire logic                 rst_n_in,                 // Async reset, active low
   input  wire logic                 fullstep_in,              // Full step pulse
   input  wire lacr_pkg::lacr_load_t raw_load_in,              // Raw load at full step
   input  wire logic                 load_filter_en_in,        // Four-reading filter enable
   input  wire logic [SENS_W-1:0]    stall_sensitivity_in,     // Signed sensitivity
   input  wire logic [3:0]           lower_load_threshold_in,  // Lower threshold, 0 = off
   input  wire logic [3:0]           upper_hysteresis_in,      // Upper threshold offset
   input  wire logic [1:0]           current_increment_width_in, // Increment select
   input  wire logic [1:0]           decrement_reading_count_in, // Decrement count select
   input  wire logic                 min_scale_quarter_in,     // Floor 1/4 when set
   input  wire lacr_pkg::lacr_scale_t run_current_scale_in,    // Run current scale
   output lacr_pkg::lacr_load_t      load_result_out,          // Load result status
   output logic                      load_result_valid_out,    // Load result update pulse
   output lacr_pkg::lacr_scale_t     actual_current_scale_out, // Actual current scale
   output logic signed [SENS_W-1:0]  sensitivity_applied_out   // Sensitivity in use
);
   import lacr_pkg::*;

   // Sensitivity width the logic can serve
   if (SENS_W < 2 || SENS_W > 8) begin : g_sens_w_bad
      $error("SENS_W out of range");
   end

   function automatic logic [5:0] lacr_inc_f(input logic [1:0] sel);
      case (sel)
         2'h0:    lacr_inc_f = 6'h01;
         2'h1:    lacr_inc_f = 6'h02;
         2'h2:    lacr_inc_f = 6'h04;
         default: lacr_inc_f = 6'h08;
      endcase
   endfunction

   function automatic logic [`LACR_CNT_W-1:0] lacr_dec_f(input logic [1:0] sel);
      case (sel)
         2'h0:    lacr_dec_f = 6'h20;
         2'h1:    lacr_dec_f = 6'h08;
         2'h2:    lacr_dec_f = 6'h02;
         default: lacr_dec_f = 6'h01;
      endcase
   endfunction

   lacr_load_t                  filt_res;
   logic                        filt_vld;
   lacr_state_t                 state_r, state_nxt;
   lacr_load_t                  load_r, load_nxt;
   logic                        vld_r, vld_nxt;
   lacr_scale_t                 scale_r, scale_nxt;
   logic [`LACR_CNT_W-1:0]      hcnt_r, hcnt_nxt;
   logic signed [SENS_W-1:0]    sens_r, sens_nxt;
   logic [`LACR_LOAD_W:0]       lo_thr, hi_thr;
   lacr_scale_t                 floor_v;
   logic [5:0]                  sum_v;

   lacr_load_filter lacr_load_filter_i (
      .mclk_in       (mclk_in),
      .rst_n_in      (rst_n_in),
      .filt_en_in    (load_filter_en_in),
      .meas_valid_in (fullstep_in),
      .meas_in       (raw_load_in),
      .res_valid_out (filt_vld),
      .res_out       (filt_res)
   );

   // Thresholds in 11 bits so the upper sum never wraps, plus the 5-bit floor
   always_comb begin
      lo_thr  = {2'h0, lower_load_threshold_in, 5'h00};
      hi_thr  = {({2'h0, lower_load_threshold_in} + {2'h0, upper_hysteresis_in} + 6'h01),
                 5'h00};
      floor_v = min_scale_quarter_in ? (run_current_scale_in >> 2)
                                     : (run_current_scale_in >> 1);
   end

   // Result path: filter pulse, register result, then adapt
   always_comb begin
      state_nxt = state_r;
      load_nxt  = load_r;
      vld_nxt   = 1'b0;
      case (state_r)
         LACR_ST_IDLE: begin
            if (filt_vld) begin
               state_nxt = LACR_ST_UPDATE;
            end
         end
         LACR_ST_UPDATE: begin
            load_nxt  = filt_res;
            vld_nxt   = 1'b1;
            state_nxt = LACR_ST_ADAPT;
         end
         default: begin
            state_nxt = LACR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= LACR_ST_IDLE;
         load_r  <= `LACR_LOAD_RST;
         vld_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         load_r  <= load_nxt;
         vld_r   <= vld_nxt;
      end
   end

   // Scale adapts one cycle after the result, on the registered value
   always_comb begin
      scale_nxt = scale_r;
      hcnt_nxt  = hcnt_r;
      sum_v     = {1'b0, scale_r} + lacr_inc_f(current_increment_width_in);
      if (state_r == LACR_ST_ADAPT && lower_load_threshold_in != 4'h0) begin
         if ({1'b0, load_r} < lo_thr) begin
            if (sum_v > {1'b0, run_current_scale_in}) begin
               scale_nxt = run_current_scale_in;
            end else begin
               scale_nxt = sum_v[`LACR_SCALE_W-1:0];
            end
            hcnt_nxt = '0;
         end else if ({1'b0, load_r} >= hi_thr) begin
            if (hcnt_r + 6'h01 >= lacr_dec_f(decrement_reading_count_in)) begin
               hcnt_nxt = '0;
               if (scale_r > floor_v) begin
                  scale_nxt = scale_r - 5'h01;
               end
            end else begin
               hcnt_nxt = hcnt_r + 6'h01;
            end
         end
      end
      if (scale_nxt > run_current_scale_in) begin
         scale_nxt = run_current_scale_in;
      end else if (scale_nxt < floor_v) begin
         scale_nxt = floor_v;
      end
      if (lower_load_threshold_in == 4'h0) begin
         scale_nxt = run_current_scale_in;
         hcnt_nxt  = '0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scale_r <= `LACR_SCALE_RST;
         hcnt_r  <= '0;
      end else begin
         scale_r <= scale_nxt;
         hcnt_r  <= hcnt_nxt;
      end
   end

   // Sensitivity only passes through to the front end
   always_comb begin
      // Signed sensitivity passed to front end
      sens_nxt = stall_sensitivity_in;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sens_r <= '0;
      end else begin
         sens_r <= sens_nxt;
      end
   end

   assign load_result_out          = load_r;
   assign load_result_valid_out    = vld_r;
   assign actual_current_scale_out = scale_r;
   assign sensitivity_applied_out  = sens_r;
endmodule // lacr_regulator

// ==== lacr_reg_chk_properties.sv ====
/* Port checker of the load adaptive current regulator.
   Assumes a bind onto lacr_regulator with its SENS_W. */
`timescale 1ns/100ps
module lacr_reg_chk
   import lacr_pkg::*;
#(parameter int SENS_W = 7)
(
   input wire logic                     mclk_in,                    // Clock
   input wire logic                     rst_n_in,                   // Reset, active low
   input wire logic                     fullstep_in,                // Step pulse
   input wire lacr_pkg::lacr_load_t     raw_load_in,                // Raw load
   input wire logic                     load_filter_en_in,          // Filter enable
   input wire logic [SENS_W-1:0]        stall_sensitivity_in,       // Sensitivity
   input wire logic [3:0]               lower_load_threshold_in,    // Lower threshold
   input wire logic [3:0]               upper_hysteresis_in,        // Hysteresis
   input wire logic [1:0]               current_increment_width_in, // Increment select
   input wire logic [1:0]               decrement_reading_count_in, // Decrement select
   input wire logic                     min_scale_quarter_in,       // Floor select
   input wire lacr_pkg::lacr_scale_t    run_current_scale_in,       // Run current
   input wire lacr_pkg::lacr_load_t     load_result_out,            // Load result
   input wire logic                     load_result_valid_out,      // Result pulse
   input wire lacr_pkg::lacr_scale_t    actual_current_scale_out,   // Actual scale
   input wire logic signed [SENS_W-1:0] sensitivity_applied_out     // Applied sensitivity
);
   wire lacr_scale_t ac = actual_current_scale_out;
   wire lacr_scale_t rn = run_current_scale_in;
   wire lacr_load_t  ld = load_result_out;
   wire logic        vl = load_result_valid_out;
   wire logic        on = lower_load_threshold_in != 4'h0;
   wire logic [8:0]  lo = {lower_load_threshold_in, 5'h0};
   wire logic [10:0] hi = {({2'h0, lower_load_threshold_in} + {2'h0, upper_hysteresis_in}
                          + 6'h1), 5'h0};
   wire lacr_scale_t flr = min_scale_quarter_in ? rn >> 2 : rn >> 1;
   wire logic [5:0]  up = {1'h0, ac} + (6'h1 << current_increment_width_in);
   wire lacr_scale_t sat = up > {1'h0, rn} ? rn : up[4:0];
   wire lacr_scale_t dwn = ac > flr ? ac - 5'h1 : flr;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   step_result_a: assert property (fullstep_in && !load_filter_en_in |->
      ##3 vl && ld == $past(raw_load_in, 3)) else $error("step result wrong");
   result_hold_a: assert property (!vl |-> $stable(ld)) else $error("result moved");
   pulse_single_a: assert property (vl |=> !vl) else $error("valid too long");
   scale_ceiling_a: assert property ($stable(rn) |=> ac <= $past(rn))
      else $error("scale above run");
   scale_floor_a: assert property ($stable(rn) && $stable(min_scale_quarter_in) |=>
      ac >= $past(flr)) else $error("scale below floor");
   off_run_a: assert property (!on && $stable(rn) |=> ac == rn)
      else $error("scale not run while off");
   low_raise_a: assert property (vl && on && ld < lo && $stable(rn) |=>
      ac == $past(sat)) else $error("raise wrong");
   high_lower_a: assert property (vl && on && ld >= hi &&
      decrement_reading_count_in == 2'h3 |=> ac == $past(dwn)) else $error("lower wrong");
   sens_copy_a: assert property (1'h1 |=>
      sensitivity_applied_out == $past(stall_sensitivity_in)) else $error("sens wrong");
endmodule // lacr_reg_chk

// ==== lacr_step_src.sv ====
/* Full step source in place of the measurement front end.
   Assumes the caller leaves at least four cycles between steps. */
`timescale 1ns/100ps
module lacr_step_src
   import lacr_pkg::*;
(
   input  wire logic            clk_in,       // Clock
   output logic                 fullstep_out, // Step pulse
   output lacr_pkg::lacr_load_t load_out      // Raw load
);
   initial begin
      fullstep_out = 1'h0;
      load_out = 10'h0;
   end
   task automatic step(input lacr_load_t v);
      @(negedge clk_in);
      fullstep_out = 1'h1;
      load_out = v;
      @(negedge clk_in);
      fullstep_out = 1'h0;
      // Stale value inverted once released
      load_out = ~v;
      repeat (4) @(negedge clk_in);
   endtask
endmodule // lacr_step_src

// ==== tb_lacr_regulator.sv ====
/* Self-checking bench of the regulator, scale tracked here.
   Assumes package, design, source and checker compile first. */
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value %s exp %0h got %0h", n, e, a); end end
module tb_lacr_regulator;
   import lacr_pkg::*;
   logic        mclk_in = 1'h0, rst_n_in = 1'h0, filt = 1'h0, minq = 1'h0, fs, vld;
   logic [6:0]  sens = 7'h0, sens_o;
   logic [3:0]  thr = 4'h0, hys = 4'h0;
   logic [1:0]  inc = 2'h0, dn = 2'h0;
   lacr_scale_t run = 5'h1f, sc;
   lacr_load_t  raw, res, res_l;
   int          error_cnt = 0, check_count = 0, vcnt = 0, ex = 31, hc = 0;
   always #2.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      if (vld) begin
         vcnt <= vcnt + 1;
         res_l <= res;
      end
   end
   lacr_step_src lacr_step_src_i (.clk_in(mclk_in), .fullstep_out(fs), .load_out(raw));
   lacr_regulator lacr_regulator_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .fullstep_in(fs), .raw_load_in(raw), .load_filter_en_in(filt),
      .stall_sensitivity_in(sens), .lower_load_threshold_in(thr),
      .upper_hysteresis_in(hys), .current_increment_width_in(inc),
      .decrement_reading_count_in(dn), .min_scale_quarter_in(minq),
      .run_current_scale_in(run), .load_result_out(res), .load_result_valid_out(vld),
      .actual_current_scale_out(sc), .sensitivity_applied_out(sens_o));
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One step; r is the expected result, negative when none is due
   task automatic step(input int v, input int r);
      int n;
      int flr;
      n = vcnt;
      flr = minq ? run >> 2 : run >> 1;
      lacr_step_src_i.step(10'(v));
      if (r < 0) begin
         `CHK("no result", n, vcnt)
      end else begin
         if (thr == 4'h0) ex = run;
         else if (r < thr * 32) begin
            ex = ex + (1 << inc) > run ? run : ex + (1 << inc);
            hc = 0;
         end else if (r >= (thr + hys + 1) * 32) begin
            hc++;
            if (hc == (dn == 2'h0 ? 32 : dn == 2'h1 ? 8 : dn == 2'h2 ? 2 : 1)) begin
               hc = 0;
               ex = ex - 1 < flr ? flr : ex - 1;
            end
         end
         `CHK("result count", n + 1, vcnt)
         `CHK("load result", r, res_l)
         `CHK("current scale", ex, sc)
      end
   endtask
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (4) @(negedge mclk_in);
      rst_n_in = 1'h1;
      repeat (2) @(negedge mclk_in);
      `CHK("off scale", 31, sc)
      step(300, 300);
      $display("test reset done");
      thr = 4'h2;
      hys = 4'h1;
      inc = 2'h3;
      for (int d = 0; d < 4; d++) begin
         dn = 2'(d);
         step(5, 5);
         repeat (d == 0 ? 32 : d == 1 ? 8 : d == 2 ? 2 : 1) step(200, 200);
      end
      step(127, 127);
      step(128, 128);
      minq = 1'h1;
      repeat (24) step(600, 600);
      $display("test decrement done");
      for (int i = 0; i < 4; i++) begin
         inc = 2'(i);
         step(63, 63);
      end
      step(64, 64);
      run = 5'hc;
      ex = 12;
      repeat (2) @(negedge mclk_in);
      `CHK("clamped scale", ex, sc)
      $display("test increment done");
      filt = 1'h1;
      step(100, -1);
      step(200, -1);
      step(300, -1);
      step(404, 251);
      filt = 1'h0;
      $display("test filter done");
      sens = 7'h7b;
      @(negedge mclk_in);
      `CHK("sensitivity", 7'h7b, sens_o)
      thr = 4'h0;
      repeat (2) @(negedge mclk_in);
      `CHK("off scale", 12, sc)
      step(1, 1);
      step(0, 0);
      $display("test config done");
      conclude();
   end
endmodule // tb_lacr_regulator
bind lacr_regulator lacr_reg_chk #(.SENS_W(SENS_W)) lacr_reg_chk_i (.*);
